// *** design/sbcs_top.v ***
// sbcs_top.v - status byte summary, service request, bus trigger gating,
// rom self-test and wait-to-continue command sequencing.
// assumes one 100 mhz clock, synchronous reset, inputs synchronous to clock,
// and a command parser that presents one decoded command per i_cmd_valid.
// Notes on behaviour
// - every status bit except bits one and six follows its source register or queue; bit one is always zero
// - bit six sets while any enabled summary condition is present
// - reading the status byte never clears it; only sources, or a new enable mask for bit six, clear it
// - status byte query returns the byte value, binary form shows bits
// - bit zero set when a measurement event is recorded
// - bit two set while the error queue holds a message
// - bit three set while the questionable summary is present
// - bit four set while output queue has a message; sent when talked
// - bit five set when an enabled standard event is recorded
// - bit seven set when an enabled operation event is recorded
// - pending service request reported as rqs during serial poll
// - trigger command acts exactly like a group execute trigger
// - bus trigger acts only when trigger source is the bus setting
// - self-test runs rom checksum, queues 0 on pass, 1 on fail
// - sequential command completes before the next one starts
// - wait command holds later commands until overlapped work finishes
// - only initiate, continuous initiate and trigger are overlapped
// - initiate leaves idle; complete only once idle again
// - bus trigger complete once trigger pointer has settled
// - service request enable mask cleared at power-up
// - service request raised when a status bit and its mask bit are set
`timescale 1ns/1ns
`include "sbcs_map.vh"
module sbcs_top #(
    parameter ROM_AW = 4
) (
    input  wire       i_clock,
    input  wire       i_rst,
    // summary sources
    input  wire       i_meas_event,
    input  wire       i_error_queue_nonempty,
    input  wire       i_questionable_summary,
    input  wire       i_outq_nonempty,
    input  wire       i_std_event_summary,
    input  wire       i_operation_summary,
    // bus side
    input  wire       i_serial_poll,
    input  wire       i_get,
    input  wire       i_talk_addressed,
    // decoded command port
    input  wire       i_cmd_valid,
    input  wire [3:0] i_cmd,
    input  wire [7:0] i_cmd_data,
    // trigger model side
    input  wire [1:0] i_trig_source,
    input  wire       i_idle,
    input  wire       i_trig_settled,
    output reg        o_cmd_ready,
    output reg        o_cmd_done,
    output reg        o_initiate,
    output reg        o_bus_trigger,
    output reg  [7:0] o_status_byte,
    output reg  [7:0] o_sre,
    output reg        o_srq,
    output reg  [7:0] o_poll_byte,
    output reg        o_poll_valid,
    output reg  [7:0] o_resp_data,
    output reg        o_resp_valid,
    output reg        o_talk_send
);
    localparam ST_IDLE = 2'd0;
    localparam ST_TEST = 2'd1;
    localparam ST_WAIT = 2'd2;
    localparam ST_SEQ  = 2'd3;

    reg [1:0]        state_ff;
    reg [1:0]        nxt_state;
    reg [ROM_AW-1:0] addr_ff;
    reg [ROM_AW-1:0] nxt_addr;
    reg [7:0]        sum_ff;
    reg [7:0]        nxt_sum;
    reg              rd_ok_ff;
    reg              nxt_rd_ok;
    reg              last_ff;
    reg              nxt_last;
    reg              init_pend_ff;
    reg              nxt_init_pend;
    reg              trg_pend_ff;
    reg              nxt_trg_pend;
    reg [7:0]        sre_ff;
    reg [7:0]        nxt_sre;
    reg [7:0]        stb_raw;
    reg              mss;
    reg              trig_fire;
    wire [7:0]       rom_data;

    // true when a command is one of the three overlapped kinds
    function is_overlapped;
        input [3:0] c;
        begin
            is_overlapped = (c == `SBCS_CMD_INIT) || (c == `SBCS_CMD_INIT_CONT)
                         || (c == `SBCS_CMD_TRG);
        end
    endfunction

    sbcs_rom #(
        .AW     (ROM_AW)
    ) u_rom (
        .i_clock (i_clock),
        .i_addr  (addr_ff),
        .o_data  (rom_data)
    );

    // status byte assembled straight from sources, mss from mask
    always @* begin
        stb_raw = `SBCS_STB_RESET;
        stb_raw[`SBCS_BIT_MEAS] = i_meas_event;
        stb_raw[`SBCS_BIT_ERRQ] = i_error_queue_nonempty;
        stb_raw[`SBCS_BIT_QUES] = i_questionable_summary;
        stb_raw[`SBCS_BIT_MAV]  = i_outq_nonempty;
        stb_raw[`SBCS_BIT_ESB]  = i_std_event_summary;
        stb_raw[`SBCS_BIT_OPER] = i_operation_summary;
        stb_raw[`SBCS_BIT_UNUSED] = 1'b0;
        mss = |(stb_raw & sre_ff & ~(8'h01 << `SBCS_BIT_MSS));
        stb_raw[`SBCS_BIT_MSS] = mss;
    end

    // bus trigger from either get or trigger command, gated by source
    always @* begin
        trig_fire = 1'b0;
        if (i_trig_source == `SBCS_SRC_BUS) begin
            trig_fire = i_get ||
                (i_cmd_valid && o_cmd_ready && i_cmd == `SBCS_CMD_TRG);
        end
    end

    // command sequencer: overlapped tracking, wait hold, self-test walk
    always @* begin
        nxt_state     = state_ff;
        nxt_addr      = addr_ff;
        nxt_sum       = sum_ff;
        nxt_rd_ok     = 1'b0;
        nxt_last      = 1'b0;
        nxt_sre       = sre_ff;
        nxt_init_pend = init_pend_ff;
        nxt_trg_pend  = trg_pend_ff;
        // initiate complete only on return to idle
        if (init_pend_ff && i_idle && !o_initiate) begin
            nxt_init_pend = 1'b0;
        end
        // trigger complete once pointer settles
        if (trg_pend_ff && i_trig_settled && !o_bus_trigger) begin
            nxt_trg_pend = 1'b0;
        end
        if (trig_fire) begin
            nxt_trg_pend = 1'b1;
        end
        case (state_ff)
            ST_IDLE: begin
                if (i_cmd_valid && o_cmd_ready) begin
                    if (is_overlapped(i_cmd)) begin
                        if (i_cmd != `SBCS_CMD_TRG) begin
                            nxt_init_pend = 1'b1;
                        end
                    end else if (i_cmd == `SBCS_CMD_WAI) begin
                        nxt_state = ST_WAIT;
                    end else if (i_cmd == `SBCS_CMD_TST) begin
                        nxt_state = ST_TEST;
                        nxt_addr  = {ROM_AW{1'b0}};
                        nxt_sum   = 8'h00;
                        nxt_rd_ok = 1'b0;                // old rom word, not summed
                    end else begin
                        if (i_cmd == `SBCS_CMD_SRE_WR) begin
                            nxt_sre = i_cmd_data;
                        end
                        nxt_state = ST_SEQ;
                    end
                end
            end
            ST_TEST: begin
                // rom data lags its address by one cycle, so add under rd_ok_ff
                if (rd_ok_ff) begin
                    nxt_sum = sum_ff + rom_data;
                end
                if (!last_ff) begin
                    nxt_rd_ok = 1'b1;
                    if (addr_ff != {ROM_AW{1'b1}}) begin
                        nxt_addr = addr_ff + {{(ROM_AW-1){1'b0}}, 1'b1};
                    end else begin
                        nxt_last = 1'b1;
                    end
                end else if (rd_ok_ff) begin
                    nxt_last = 1'b1;                         // final word still adding
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (!init_pend_ff && !trg_pend_ff) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SEQ: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state registers
    always @(posedge i_clock) begin
        if (i_rst) begin
            state_ff     <= ST_IDLE;
            addr_ff      <= {ROM_AW{1'b0}};
            sum_ff       <= 8'h00;
            rd_ok_ff     <= 1'b0;
            last_ff      <= 1'b0;
            init_pend_ff <= 1'b0;
            trg_pend_ff  <= 1'b0;
            sre_ff       <= `SBCS_SRE_RESET;
        end else begin
            state_ff     <= nxt_state;
            addr_ff      <= nxt_addr;
            sum_ff       <= nxt_sum;
            rd_ok_ff     <= nxt_rd_ok;
            last_ff      <= nxt_last;
            init_pend_ff <= nxt_init_pend;
            trg_pend_ff  <= nxt_trg_pend;
            sre_ff       <= nxt_sre;
        end
    end

    // registered outputs
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_cmd_ready   <= 1'b0;
            o_cmd_done    <= 1'b0;
            o_initiate    <= 1'b0;
            o_bus_trigger <= 1'b0;
            o_status_byte <= `SBCS_STB_RESET;
            o_sre         <= `SBCS_SRE_RESET;
            o_srq         <= 1'b0;
            o_poll_byte   <= `SBCS_STB_RESET;
            o_poll_valid  <= 1'b0;
            o_resp_data   <= 8'h00;
            o_resp_valid  <= 1'b0;
            o_talk_send   <= 1'b0;
        end else begin
            o_cmd_ready   <= (nxt_state == ST_IDLE) && !(i_cmd_valid && o_cmd_ready);
            o_cmd_done    <= (state_ff == ST_IDLE && i_cmd_valid && o_cmd_ready
                              && nxt_state == ST_IDLE) || (state_ff != ST_IDLE
                              && nxt_state == ST_IDLE);
            o_initiate    <= (state_ff == ST_IDLE) && i_cmd_valid && o_cmd_ready
                              && (i_cmd == `SBCS_CMD_INIT || i_cmd == `SBCS_CMD_INIT_CONT);
            o_bus_trigger <= trig_fire;
            o_status_byte <= stb_raw;
            o_sre         <= nxt_sre;
            o_srq         <= mss;
            o_poll_valid  <= i_serial_poll;
            o_poll_byte   <= stb_raw;
            o_talk_send   <= i_talk_addressed && i_outq_nonempty;
            o_resp_valid  <= 1'b0;
            if (state_ff == ST_IDLE && i_cmd_valid && o_cmd_ready) begin
                if (i_cmd == `SBCS_CMD_STB_RD) begin
                    o_resp_data  <= stb_raw;
                    o_resp_valid <= 1'b1;
                end else if (i_cmd == `SBCS_CMD_SRE_RD) begin
                    o_resp_data  <= sre_ff;
                    o_resp_valid <= 1'b1;
                end
            end
            if (state_ff == ST_TEST && last_ff && !rd_ok_ff) begin
                o_resp_data  <= (sum_ff == 8'h00) ? `SBCS_TST_PASS
                                                  : `SBCS_TST_FAIL;
                o_resp_valid <= 1'b1;
            end
        end
    end
endmodule

// *** design/sbcs_map.vh ***
// sbcs_map.vh - constants for the status byte / command sync block
// assumes inclusion by bare name from the design files
`ifndef SBCS_MAP_VH
`define SBCS_MAP_VH
// status byte bit positions
`define SBCS_BIT_MEAS      0
`define SBCS_BIT_UNUSED    1
`define SBCS_BIT_ERRQ      2
`define SBCS_BIT_QUES      3
`define SBCS_BIT_MAV       4
`define SBCS_BIT_ESB       5
`define SBCS_BIT_MSS       6
`define SBCS_BIT_OPER      7
// reset values
`define SBCS_SRE_RESET     8'h00
`define SBCS_STB_RESET     8'h00
// command codes on the command port
`define SBCS_CMD_NONE      4'h0
`define SBCS_CMD_INIT      4'h1
`define SBCS_CMD_INIT_CONT 4'h2
`define SBCS_CMD_TRG       4'h3
`define SBCS_CMD_WAI       4'h4
`define SBCS_CMD_TST       4'h5
`define SBCS_CMD_SRE_WR    4'h6
`define SBCS_CMD_STB_RD    4'h7
`define SBCS_CMD_SRE_RD    4'h8
`define SBCS_CMD_OTHER     4'h9
// self-test result codes
`define SBCS_TST_PASS      8'h00
`define SBCS_TST_FAIL      8'h01
// trigger source selection code for bus trigger
`define SBCS_SRC_BUS       2'h1
`endif

// *** design/sbcs_rom.v ***
// sbcs_rom.v - small firmware rom image read by the self-test checksum walker
// assumes one clock; read data registered, one cycle latency
`timescale 1ns/1ns
module sbcs_rom #(
    parameter AW = 4
) (
    input  wire          i_clock,
    input  wire [AW-1:0] i_addr,
    output reg  [7:0]    o_data
);
    // constant contents; the last word balances the sum to zero mod 256
    function [7:0] rom_word;
        input [AW-1:0] a;
        begin
            rom_word = {4'h0, a[3:0]} ^ 8'h5a;
            if (a == {AW{1'b1}}) begin
                rom_word = 8'hdd;
            end
        end
    endfunction

    // registered read port
    always @(posedge i_clock) begin
        o_data <= rom_word(i_addr);
    end
endmodule

// *** tb/sbcs_monitor.sv ***
// sbcs_monitor.sv - concurrent checks on the status byte and command sync top
// assumes it is bound onto sbcs_top and sees only that module's ports
`timescale 1ns/1ns
`include "sbcs_map.vh"
module sbcs_monitor (
    input wire       i_clock,
    input wire       i_rst,
    input wire       i_meas_event,
    input wire       i_error_queue_nonempty,
    input wire       i_questionable_summary,
    input wire       i_outq_nonempty,
    input wire       i_std_event_summary,
    input wire       i_operation_summary,
    input wire       i_get,
    input wire       i_cmd_valid,
    input wire [3:0] i_cmd,
    input wire [1:0] i_trig_source,
    input wire       o_cmd_ready,
    input wire       o_initiate,
    input wire       o_bus_trigger,
    input wire [7:0] o_status_byte,
    input wire [7:0] o_sre,
    input wire       o_srq,
    input wire [7:0] o_resp_data,
    input wire       o_resp_valid
);
    reg  [1:0] up_ff;
    wire       take   = i_cmd_valid && o_cmd_ready;
    wire       masked = |(o_status_byte & o_sre & 8'hBF);
    wire       trg_in = (i_get || (take && i_cmd == `SBCS_CMD_TRG))
                        && i_trig_source == `SBCS_SRC_BUS;
    // cycles since reset, saturating so the pipeline has filled
    always @(posedge i_clock) begin
        if (i_rst)
            up_ff <= 2'h0;
        else if (up_ff != 2'h3)
            up_ff <= up_ff + 2'h1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_hit; masked [*3]; endsequence
    sequence s_miss; !masked [*3]; endsequence
    sequence s_tst; ##[1:40] (o_resp_valid && o_resp_data == `SBCS_TST_PASS); endsequence
    AST_BIT1_ZERO: assert property (o_status_byte[1] == 1'b0)
        else $error("status bit one set");
    AST_SRC_MAP: assert property (up_ff == 2'h3 |-> (o_status_byte & 8'hBD) ==
        $past({i_operation_summary, 1'b0, i_std_event_summary, i_outq_nonempty,
        i_questionable_summary, i_error_queue_nonempty, 1'b0, i_meas_event}))
        else $error("status bits do not follow sources");
    AST_MSS_SET: assert property (s_hit |-> o_status_byte[6])
        else $error("master summary missing");
    AST_MSS_CLR: assert property (s_miss |-> !o_status_byte[6])
        else $error("master summary stuck");
    AST_SRQ_MSS: assert property (o_srq == o_status_byte[6])
        else $error("service request differs from summary");
    AST_SRE_RESET: assert property ($fell(i_rst) |-> o_sre == `SBCS_SRE_RESET)
        else $error("mask not cleared by reset");
    AST_STB_READ: assert property (take && i_cmd == `SBCS_CMD_STB_RD |=> o_resp_valid)
        else $error("status query unanswered");
    AST_NO_BACK: assert property (take |=> !o_cmd_ready)
        else $error("command taken back to back");
    AST_TRG_CAUSE: assert property (o_bus_trigger |-> $past(trg_in))
        else $error("trigger without bus source");
    AST_TRG_ON: assert property (trg_in |=> o_bus_trigger)
        else $error("bus trigger lost");
    AST_INIT: assert property (take && (i_cmd == `SBCS_CMD_INIT ||
        i_cmd == `SBCS_CMD_INIT_CONT) |=> o_initiate)
        else $error("initiate pulse missing");
    AST_TST: assert property (take && i_cmd == `SBCS_CMD_TST |-> s_tst)
        else $error("self test result missing");
endmodule
bind sbcs_top sbcs_monitor sbcs_monitor_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_meas_event(i_meas_event), .i_error_queue_nonempty(i_error_queue_nonempty),
    .i_questionable_summary(i_questionable_summary), .i_outq_nonempty(i_outq_nonempty),
    .i_std_event_summary(i_std_event_summary), .i_operation_summary(i_operation_summary),
    .i_get(i_get), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_trig_source(i_trig_source),
    .o_cmd_ready(o_cmd_ready), .o_initiate(o_initiate), .o_bus_trigger(o_bus_trigger),
    .o_status_byte(o_status_byte), .o_sre(o_sre), .o_srq(o_srq),
    .o_resp_data(o_resp_data), .o_resp_valid(o_resp_valid));

// *** tb/sbcs_host.sv ***
// sbcs_host.sv - host controller model presenting one decoded command at a time
// assumes the bench pulses i_go for one cycle while the model is idle
`timescale 1ns/1ns
module sbcs_host (
    input  wire       i_clock,
    input  wire       i_rst,
    input  wire       i_go,
    input  wire [3:0] i_op,
    input  wire [7:0] i_arg,
    input  wire       i_cmd_ready,
    output reg        o_cmd_valid,
    output reg  [3:0] o_cmd,
    output reg  [7:0] o_cmd_data
);
    // hold a command until taken, then scramble the released lines
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_cmd_valid <= 1'b0;
            o_cmd       <= 4'h0;
            o_cmd_data  <= 8'h00;
        end else if (i_go) begin
            o_cmd_valid <= 1'b1;
            o_cmd       <= i_op;
            o_cmd_data  <= i_arg;
        end else if (o_cmd_valid && i_cmd_ready) begin
            o_cmd_valid <= 1'b0;
            o_cmd       <= ~o_cmd;
            o_cmd_data  <= ~o_cmd_data;
        end
    end
endmodule

// *** tb/test_status_byte_command_sync.sv ***
// test_status_byte_command_sync.sv - self-checking bench for sbcs_top
// assumes the host model drives the command port and the bench all else
`timescale 1ns/1ns
`include "sbcs_map.vh"
module test_status_byte_command_sync;
    reg        i_clock, i_rst, poll, get, talk, idle, go, settle;
    reg  [7:0] src, arg, last_resp, trig_cnt, init_cnt, done_cnt;
    wire       done;
    reg  [3:0] op;
    reg  [1:0] tsrc;
    wire       hv, o_cmd_ready, o_initiate, o_bus_trigger, o_srq;
    wire       o_poll_valid, o_resp_valid, o_talk_send;
    wire [3:0] hc;
    wire [7:0] hd, o_status_byte, o_sre, o_poll_byte, o_resp_data;
    integer    fail_count, samples_checked;
    sbcs_top sbcs_top_inst (.i_clock(i_clock), .i_rst(i_rst), .i_meas_event(src[0]),
        .i_error_queue_nonempty(src[2]), .i_questionable_summary(src[3]),
        .i_outq_nonempty(src[4]), .i_std_event_summary(src[5]),
        .i_operation_summary(src[7]), .i_serial_poll(poll), .i_get(get),
        .i_talk_addressed(talk), .i_cmd_valid(hv), .i_cmd(hc), .i_cmd_data(hd),
        .i_trig_source(tsrc), .i_idle(idle), .i_trig_settled(settle),
        .o_cmd_ready(o_cmd_ready), .o_cmd_done(done), .o_initiate(o_initiate),
        .o_bus_trigger(o_bus_trigger), .o_status_byte(o_status_byte), .o_sre(o_sre),
        .o_srq(o_srq), .o_poll_byte(o_poll_byte), .o_poll_valid(o_poll_valid),
        .o_resp_data(o_resp_data), .o_resp_valid(o_resp_valid), .o_talk_send(o_talk_send));
    sbcs_host sbcs_host_inst (.i_clock(i_clock), .i_rst(i_rst), .i_go(go), .i_op(op),
        .i_arg(arg), .i_cmd_ready(o_cmd_ready), .o_cmd_valid(hv), .o_cmd(hc),
        .o_cmd_data(hd));
    // free-running 100 mhz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // count pulses and keep the last answer
    always @(posedge i_clock) begin
        if (i_rst) begin
            last_resp <= 8'h00;
            trig_cnt  <= 8'h00;
            init_cnt  <= 8'h00;
            done_cnt  <= 8'h00;
        end else begin
            if (o_resp_valid) last_resp <= o_resp_data;
            if (o_bus_trigger) trig_cnt <= trig_cnt + 8'h01;
            if (o_initiate) init_cnt <= init_cnt + 8'h01;
            if (done) done_cnt <= done_cnt + 8'h01;
        end
    end
    task cyc(input integer n); begin repeat (n) @(posedge i_clock); #1; end endtask
    task chk(input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task send(input [3:0] c, input [7:0] d);
        integer k;
        begin
            k = 0;
            @(posedge i_clock) begin go <= 1'b1; op <= c; arg <= d; end
            @(posedge i_clock) go <= 1'b0;
            #1;
            while (hv !== 1'b0 && k < 300) begin @(posedge i_clock); #1; k = k + 1; end
            if (k >= 300) chk(8'h00, 8'h01);
        end
    endtask
    task complete_run;
        begin
            $display("checked=%0d failed=%0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task t_map;
        integer i;
        reg [7:0] n;
        begin
            for (i = 0; i < 8; i = i + 1) if (i != 1 && i != 6) begin
                @(posedge i_clock) src <= 8'h01 << i;
                cyc(3);
                chk(o_status_byte, 8'h01 << i);
                n = done_cnt;
                send(`SBCS_CMD_STB_RD, 8'h00);
                cyc(2);
                chk(last_resp, 8'h01 << i);
                chk(done_cnt - n, 8'h01);
                chk(o_status_byte, 8'h01 << i);
            end
            @(posedge i_clock) src <= 8'hBD;
            cyc(3);
            chk(o_status_byte, 8'hBD);
            @(posedge i_clock) src <= 8'h00;
            cyc(3);
            chk(o_status_byte, 8'h00);
        end
    endtask
    task t_srq;
        begin
            send(`SBCS_CMD_SRE_WR, 8'h10);
            @(posedge i_clock) src <= 8'h14;
            cyc(4);
            chk(o_status_byte, 8'h54);
            send(`SBCS_CMD_SRE_RD, 8'h00);
            cyc(2);
            chk(last_resp, 8'h10);
            @(posedge i_clock) begin poll <= 1'b1; talk <= 1'b1; end
            cyc(2);
            chk(o_poll_byte, 8'h54);
            chk({6'h00, o_poll_valid, o_talk_send}, 8'h03);
            @(posedge i_clock) begin poll <= 1'b0; talk <= 1'b0; src <= 8'h04; end
            cyc(4);
            chk({o_status_byte[7:1], o_srq}, 8'h04);
            send(`SBCS_CMD_SRE_WR, 8'h00);
            @(posedge i_clock) src <= 8'h00;
        end
    endtask
    task t_trig;
        integer s;
        reg [7:0] n;
        begin
            n = trig_cnt;
            for (s = 0; s < 4; s = s + 1) begin
                @(posedge i_clock) tsrc <= s[1:0];
                send(`SBCS_CMD_TRG, 8'h00);
                @(posedge i_clock) get <= 1'b1;
                @(posedge i_clock) get <= 1'b0;
                cyc(3);
                chk(trig_cnt - n, (s == `SBCS_SRC_BUS) ? 8'h02 : 8'h00);
                n = trig_cnt;
            end
        end
    endtask
    task t_wai;
        integer k;
        reg [7:0] n;
        begin
            @(posedge i_clock) idle <= 1'b0;
            send(`SBCS_CMD_OTHER, 8'h00);
            send(`SBCS_CMD_WAI, 8'h00);
            cyc(4);
            chk({7'h00, o_cmd_ready}, 8'h01);
            for (k = 0; k < 2; k = k + 1) begin
                n = init_cnt;
                send(k ? `SBCS_CMD_INIT_CONT : `SBCS_CMD_INIT, 8'h00);
                send(`SBCS_CMD_WAI, 8'h00);
                cyc(10);
                chk({7'h00, o_cmd_ready}, 8'h00);
                chk(init_cnt - n, 8'h01);
                @(posedge i_clock) idle <= 1'b1;
                @(posedge i_clock) idle <= 1'b0;
                cyc(4);
                chk({7'h00, o_cmd_ready}, 8'h01);
            end
            @(posedge i_clock) begin tsrc <= `SBCS_SRC_BUS; settle <= 1'b0; end
            send(`SBCS_CMD_TRG, 8'h00);
            send(`SBCS_CMD_WAI, 8'h00);
            cyc(6);
            chk({7'h00, o_cmd_ready}, 8'h00);
            @(posedge i_clock) settle <= 1'b1;
            cyc(4);
            chk({7'h00, o_cmd_ready}, 8'h01);
            @(posedge i_clock) idle <= 1'b1;
            send(`SBCS_CMD_TST, 8'h00);
            cyc(40);
            chk(last_resp, `SBCS_TST_PASS);
        end
    endtask
    // watchdog cuts a hang short
    initial begin
        #100000;
        fail_count = fail_count + 1;
        complete_run;
    end
    // reset, then run every scenario
    initial begin
        i_rst = 1'b1; poll = 1'b0; get = 1'b0; talk = 1'b0; idle = 1'b1; go = 1'b0;
        src = 8'h00; arg = 8'h00; op = 4'h0; tsrc = 2'h0; settle = 1'b1;
        fail_count = 0; samples_checked = 0;
        repeat (20) @(posedge i_clock);
        i_rst <= 1'b0;
        cyc(3);
        chk(o_sre, `SBCS_SRE_RESET);
        t_map;
        t_srq;
        t_trig;
        t_wai;
        complete_run;
    end
endmodule
